// ---- cts_pkg.sv ----
// Shared constants and types for the cache tag, coprocessor scan and core clock switch block
`default_nettype none

package cts_pkg;

	// ==========================================================
	// Test access port states
	typedef enum logic [3:0] {
		CTS_TLR = 4'h0,
		CTS_RTI = 4'h1,
		CTS_SDS = 4'h2,
		CTS_CDR = 4'h3,
		CTS_SDR = 4'h4,
		CTS_E1D = 4'h5,
		CTS_PDR = 4'h6,
		CTS_E2D = 4'h7,
		CTS_UDR = 4'h8,
		CTS_SIS = 4'h9,
		CTS_CIR = 4'hA,
		CTS_SIR = 4'hB,
		CTS_E1I = 4'hC,
		CTS_PIR = 4'hD,
		CTS_E2I = 4'hE,
		CTS_UIR = 4'hF
	} cts_tap_t;

	// Which serial register sits between data in and data out
	typedef enum logic [1:0] {
		CTS_P_BYP = 2'h0,
		CTS_P_SEL = 2'h1,
		CTS_P_TAG = 2'h2,
		CTS_P_CP = 2'h3
	} cts_path_t;

	// ==========================================================
	// Instruction codes (arbitrary plain values)
	localparam logic [3:0] CTS_IR_EXTEST = 4'h0;
	localparam logic [3:0] CTS_IR_SCAN_SEL = 4'h2;
	localparam logic [3:0] CTS_IR_RESUME = 4'h4;
	localparam logic [3:0] CTS_IR_INTERNAL_TEST = 4'hC;
	localparam logic [3:0] CTS_IR_BYPASS = 4'hF;
	localparam logic [3:0] CTS_IR_RESET = 4'hF;
	localparam logic [3:0] CTS_IR_CAPTURE = 4'h1;

	// ==========================================================
	// Chain numbers and chain select register
	localparam logic [4:0] CTS_CHAIN_TEST = 5'h00;
	localparam logic [4:0] CTS_CHAIN_DEBUG = 5'h01;
	localparam logic [4:0] CTS_CHAIN_ICACHE = 5'h04;
	localparam logic [4:0] CTS_CHAIN_DCACHE = 5'h05;
	localparam logic [4:0] CTS_CHAIN_CP = 5'h0F;
	localparam logic [4:0] CTS_CHAIN_RESET = 5'h03;
	localparam logic [4:0] CTS_CHAIN_CAPTURE = 5'h10;

	// ==========================================================
	// Serial register lengths and field positions
	localparam int CTS_SEL_LEN = 5;
	localparam int CTS_TAG_LEN = 29;
	localparam int CTS_CP_LEN = 39;
	localparam int CTS_SEG_LSB = 0;
	localparam int CTS_SEG_USED = 2;
	localparam int CTS_IDX_LSB = 22;
	localparam int CTS_IDX_USED = 6;
	localparam int CTS_VALID_BIT = 28;
	localparam int CTS_DIRTY_BIT = 27;
	localparam int CTS_TAG_W = 27;
	localparam int CTS_CP_DIR_BIT = 38;
	localparam int CTS_CP_ADDR_LSB = 32;
	localparam int CTS_CP_ADDR_W = 6;
	localparam int CTS_CP_DATA_W = 32;

	// Synchronised pin vector layout
	localparam int CTS_PIN_W = 5;
	localparam int CTS_PIN_TCK = 0;
	localparam int CTS_PIN_TMS = 1;
	localparam int CTS_PIN_TDI = 2;
	localparam int CTS_PIN_MCLK = 3;
	localparam int CTS_PIN_STALL = 4;

endpackage

`default_nettype wire

// ---- cts_sync2.sv ----
// Two flip-flop synchroniser for pins arriving from outside the reference clock domain
`default_nettype none

module cts_sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} cts_sync_st_t;

	cts_sync_st_t s_r;
	cts_sync_st_t s_nxt;

	// The first stage feeds only the second stage
	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = async_in;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sync_out = s_r.stable;

endmodule

`default_nettype wire

// ---- cts_clk_switch.sv ----
// Glitch-free switch of the core clock between memory clock and debug clock
`default_nettype none

module cts_clk_switch (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic want_debug,
	input wire logic immediate,
	input wire logic mem_lvl,
	input wire logic dbg_lvl,
	output logic sel_debug,
	output logic clk_out
);

	typedef struct packed {
		logic mem_q;
		logic sel;
		logic clk;
	} cts_sw_st_t;

	cts_sw_st_t s_r;
	cts_sw_st_t s_nxt;
	logic mem_fall;

	always_comb begin
		s_nxt = s_r;
		s_nxt.mem_q = mem_lvl;
		mem_fall = s_r.mem_q & ~mem_lvl;
		// Change only with both clocks low so no pulse is cut short
		if ((want_debug != s_r.sel) && !mem_lvl && !dbg_lvl && (mem_fall || immediate)) begin
			s_nxt.sel = want_debug;
		end
		s_nxt.clk = s_nxt.sel ? dbg_lvl : mem_lvl;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sel_debug = s_r.sel;
	assign clk_out = s_r.clk;

endmodule

`default_nettype wire

// ---- cts_debug_scan.sv ----
// Test port scan chains for cache tags and control coprocessor, with core clock selection
`default_nettype none

// Behaviour
// - Address mode: segment from bits 5:0, index from 28:22, bits 21:6 ignored; only segment bits 1:0 are decoded.
// - Index uses bits 27:22 for 64 entries; bit 28 kept zero.
// - Read mode: valid at bit 28, dirty at 27, tag in 26:0.
// - Update loads addressed tag entry into serial register in read format.
// - Chain 4 reaches instruction tags, chain 5 data tags, same formats.
// - Coprocessor chain is 39 bits: direction, 6-bit address, 32-bit value.
// - Capture leaves coprocessor chain unchanged and starts no access.
// - Update reads coprocessor register when bit 38 low, writes when high.
// - Outside debug, except under chain 0 internal test, core uses memory clock; debug clock held low.
// - In debug core uses debug clock paced by port; selected clock output.
// - Memory stall input ignored while core runs from debug clock.
// - Acknowledge raised in memory clock high phase; switch at next falling edge.
// - With resume loaded, entering run-test/idle returns core to memory clock.
// - Chain 0 internal test, or chain 1 internal test in debug, pulses debug clock in run-test/idle; none otherwise.
// - Chain select update chooses the active chain for later data scans.
module cts_debug_scan (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic memory_clock,
	input wire logic memory_stall_n,
	input wire logic debug_entry_req,
	input wire logic tag_rd_ack,
	input wire logic tag_rd_valid,
	input wire logic tag_rd_dirty,
	input wire logic [cts_pkg::CTS_TAG_W-1:0] tag_rd_tag,
	input wire logic cp_ack,
	input wire logic [cts_pkg::CTS_CP_DATA_W-1:0] cp_rdata,
	output logic tdo,
	output logic tdo_en,
	output logic debug_acknowledge,
	output logic debug_core_clock,
	output logic selected_clock_out,
	output logic core_on_debug_clock,
	output logic core_stall_n,
	output logic [4:0] active_chain,
	output logic tag_rd_req,
	output logic tag_rd_dcache,
	output logic [cts_pkg::CTS_SEG_USED-1:0] tag_rd_segment,
	output logic [cts_pkg::CTS_IDX_USED-1:0] tag_rd_index,
	output logic cp_req,
	output logic cp_write,
	output logic [cts_pkg::CTS_CP_ADDR_W-1:0] cp_addr,
	output logic [cts_pkg::CTS_CP_DATA_W-1:0] cp_wdata
);

	// ==========================================================
	// State
	typedef struct packed {
		cts_pkg::cts_tap_t tap;
		logic [3:0] ir;
		logic [3:0] ir_sh;
		logic [4:0] chain;
		logic [cts_pkg::CTS_CP_LEN-1:0] dr;
		logic tck_q;
		logic tdo;
		logic tdo_en;
		logic dbg_ack;
		logic dbg_clk;
		logic stall_n;
		logic tag_req;
		logic tag_dc;
		logic [cts_pkg::CTS_SEG_USED-1:0] tag_seg;
		logic [cts_pkg::CTS_IDX_USED-1:0] tag_idx;
		logic cp_req;
		logic cp_wr;
		logic [cts_pkg::CTS_CP_ADDR_W-1:0] cp_addr;
		logic [cts_pkg::CTS_CP_DATA_W-1:0] cp_wdata;
	} cts_main_st_t;

	localparam cts_main_st_t CTS_MAIN_RESET = '{
		tap: cts_pkg::CTS_TLR,
		ir: cts_pkg::CTS_IR_RESET,
		ir_sh: 4'h0,
		chain: cts_pkg::CTS_CHAIN_RESET,
		dr: '0,
		tck_q: 1'b0,
		tdo: 1'b0,
		tdo_en: 1'b0,
		dbg_ack: 1'b0,
		dbg_clk: 1'b0,
		stall_n: 1'b1,
		tag_req: 1'b0,
		tag_dc: 1'b0,
		tag_seg: '0,
		tag_idx: '0,
		cp_req: 1'b0,
		cp_wr: 1'b0,
		cp_addr: '0,
		cp_wdata: '0
	};

	cts_main_st_t s_r;
	cts_main_st_t s_nxt;

	logic [cts_pkg::CTS_PIN_W-1:0] pins_s;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic mclk_s;
	logic stall_s;
	logic sel_debug;
	logic want_debug;
	logic test_mode;
	logic tck_rise;
	logic tck_fall;
	cts_pkg::cts_path_t path;
	cts_pkg::cts_tap_t tap_after;
	logic debug_core_clock_chain;

	// ==========================================================
	// Decoding helpers
	function automatic cts_pkg::cts_tap_t tap_next(input cts_pkg::cts_tap_t st, input logic m);
		cts_pkg::cts_tap_t r;
		r = st;
		unique case (st)
			cts_pkg::CTS_TLR: r = m ? cts_pkg::CTS_TLR : cts_pkg::CTS_RTI;
			cts_pkg::CTS_RTI: r = m ? cts_pkg::CTS_SDS : cts_pkg::CTS_RTI;
			cts_pkg::CTS_SDS: r = m ? cts_pkg::CTS_SIS : cts_pkg::CTS_CDR;
			cts_pkg::CTS_CDR: r = m ? cts_pkg::CTS_E1D : cts_pkg::CTS_SDR;
			cts_pkg::CTS_SDR: r = m ? cts_pkg::CTS_E1D : cts_pkg::CTS_SDR;
			cts_pkg::CTS_E1D: r = m ? cts_pkg::CTS_UDR : cts_pkg::CTS_PDR;
			cts_pkg::CTS_PDR: r = m ? cts_pkg::CTS_E2D : cts_pkg::CTS_PDR;
			cts_pkg::CTS_E2D: r = m ? cts_pkg::CTS_UDR : cts_pkg::CTS_SDR;
			cts_pkg::CTS_UDR: r = m ? cts_pkg::CTS_SDS : cts_pkg::CTS_RTI;
			cts_pkg::CTS_SIS: r = m ? cts_pkg::CTS_TLR : cts_pkg::CTS_CIR;
			cts_pkg::CTS_CIR: r = m ? cts_pkg::CTS_E1I : cts_pkg::CTS_SIR;
			cts_pkg::CTS_SIR: r = m ? cts_pkg::CTS_E1I : cts_pkg::CTS_SIR;
			cts_pkg::CTS_E1I: r = m ? cts_pkg::CTS_UIR : cts_pkg::CTS_PIR;
			cts_pkg::CTS_PIR: r = m ? cts_pkg::CTS_E2I : cts_pkg::CTS_PIR;
			cts_pkg::CTS_E2I: r = m ? cts_pkg::CTS_UIR : cts_pkg::CTS_SIR;
			cts_pkg::CTS_UIR: r = m ? cts_pkg::CTS_SDS : cts_pkg::CTS_RTI;
		endcase
		return r;
	endfunction

	// Chain path only opens under internal test; unlisted chains fall back to bypass
	function automatic cts_pkg::cts_path_t path_of(input logic [3:0] ir, input logic [4:0] chain);
		cts_pkg::cts_path_t p;
		p = cts_pkg::CTS_P_BYP;
		if (ir == cts_pkg::CTS_IR_SCAN_SEL) begin
			p = cts_pkg::CTS_P_SEL;
		end else if (ir == cts_pkg::CTS_IR_INTERNAL_TEST) begin
			if (chain == cts_pkg::CTS_CHAIN_ICACHE || chain == cts_pkg::CTS_CHAIN_DCACHE) begin
				p = cts_pkg::CTS_P_TAG;
			end else if (chain == cts_pkg::CTS_CHAIN_CP) begin
				p = cts_pkg::CTS_P_CP;
			end
		end
		return p;
	endfunction

	// Shift toward bit 0, data in enters at the top bit of the selected length
	function automatic logic [cts_pkg::CTS_CP_LEN-1:0] dr_shift(
		input logic [cts_pkg::CTS_CP_LEN-1:0] dr,
		input logic din,
		input cts_pkg::cts_path_t p
	);
		logic [cts_pkg::CTS_CP_LEN-1:0] r;
		r = dr >> 1;
		unique case (p)
			cts_pkg::CTS_P_BYP: r[0] = din;
			cts_pkg::CTS_P_SEL: r[cts_pkg::CTS_SEL_LEN-1] = din;
			cts_pkg::CTS_P_TAG: r[cts_pkg::CTS_TAG_LEN-1] = din;
			cts_pkg::CTS_P_CP: r[cts_pkg::CTS_CP_LEN-1] = din;
		endcase
		return r;
	endfunction

	// ==========================================================
	// Pin synchronisation and clock switch
	// All pins pass the same two flops, so they keep their timing relative to each other
	cts_sync2 #(
		.W(cts_pkg::CTS_PIN_W)
	) u_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in({memory_stall_n, memory_clock, tdi, tms, tck}),
		.sync_out(pins_s)
	);

	assign tck_s = pins_s[cts_pkg::CTS_PIN_TCK];
	assign tms_s = pins_s[cts_pkg::CTS_PIN_TMS];
	assign tdi_s = pins_s[cts_pkg::CTS_PIN_TDI];
	assign mclk_s = pins_s[cts_pkg::CTS_PIN_MCLK];
	assign stall_s = pins_s[cts_pkg::CTS_PIN_STALL];

	// Serial test holds the memory clock low, so no falling edge will come
	assign test_mode = (s_r.ir == cts_pkg::CTS_IR_INTERNAL_TEST) && (s_r.chain == cts_pkg::CTS_CHAIN_TEST);
	assign want_debug = s_r.dbg_ack | test_mode;

	// Debug clock may run under internal test on chain 0, or on chain 1 while in debug
	assign debug_core_clock_chain = (s_r.ir == cts_pkg::CTS_IR_INTERNAL_TEST) &&
		(s_r.chain == cts_pkg::CTS_CHAIN_TEST || (s_r.dbg_ack && s_r.chain == cts_pkg::CTS_CHAIN_DEBUG));

	// The switch sees the next debug level, so it never lands on the edge that starts a pulse
	cts_clk_switch u_switch (
		.ref_clk(ref_clk),
		.rst(rst),
		.want_debug(want_debug),
		.immediate(test_mode),
		.mem_lvl(mclk_s),
		.dbg_lvl(s_nxt.dbg_clk),
		.sel_debug(sel_debug),
		.clk_out(selected_clock_out)
	);

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.tck_q = tck_s;
		tck_rise = tck_s & ~s_r.tck_q;
		tck_fall = ~tck_s & s_r.tck_q;
		path = path_of(s_r.ir, s_r.chain);
		tap_after = tap_next(s_r.tap, tms_s);

		// Side accesses end when the far logic answers
		// A new update overwrites an access still in flight, so the debugger must wait it out
		if (s_r.tag_req && tag_rd_ack) begin
			s_nxt.tag_req = 1'b0;
			s_nxt.dr[cts_pkg::CTS_VALID_BIT] = tag_rd_valid;
			s_nxt.dr[cts_pkg::CTS_DIRTY_BIT] = tag_rd_dirty;
			s_nxt.dr[cts_pkg::CTS_TAG_W-1:0] = tag_rd_tag;
		end
		if (s_r.cp_req && cp_ack) begin
			s_nxt.cp_req = 1'b0;
			if (!s_r.cp_wr) begin
				s_nxt.dr[cts_pkg::CTS_CP_DATA_W-1:0] = cp_rdata;
			end
		end

		if (tck_rise) begin
			s_nxt.tap = tap_after;
			if (s_r.tap == cts_pkg::CTS_TLR) begin
				s_nxt.ir = cts_pkg::CTS_IR_RESET;
			end else if (s_r.tap == cts_pkg::CTS_CDR) begin
				// Tag and coprocessor paths keep their contents here
				if (path == cts_pkg::CTS_P_SEL) begin
					s_nxt.dr[cts_pkg::CTS_SEL_LEN-1:0] = cts_pkg::CTS_CHAIN_CAPTURE;
				end else if (path == cts_pkg::CTS_P_BYP) begin
					s_nxt.dr[0] = 1'b0;
				end
			end else if (s_r.tap == cts_pkg::CTS_SDR) begin
				s_nxt.dr = dr_shift(s_r.dr, tdi_s, path);
			end else if (s_r.tap == cts_pkg::CTS_UDR) begin
				if (path == cts_pkg::CTS_P_SEL) begin
					s_nxt.chain = s_r.dr[cts_pkg::CTS_SEL_LEN-1:0];
				end else if (path == cts_pkg::CTS_P_TAG) begin
					// Bits 21:6, segment bits above 1 and index bit 28 are not decoded
					s_nxt.tag_req = 1'b1;
					s_nxt.tag_dc = (s_r.chain == cts_pkg::CTS_CHAIN_DCACHE);
					s_nxt.tag_seg = s_r.dr[cts_pkg::CTS_SEG_LSB +: cts_pkg::CTS_SEG_USED];
					s_nxt.tag_idx = s_r.dr[cts_pkg::CTS_IDX_LSB +: cts_pkg::CTS_IDX_USED];
				end else if (path == cts_pkg::CTS_P_CP) begin
					s_nxt.cp_req = 1'b1;
					s_nxt.cp_wr = s_r.dr[cts_pkg::CTS_CP_DIR_BIT];
					s_nxt.cp_addr = s_r.dr[cts_pkg::CTS_CP_ADDR_LSB +: cts_pkg::CTS_CP_ADDR_W];
					s_nxt.cp_wdata = s_r.dr[cts_pkg::CTS_CP_DATA_W-1:0];
				end
			end else if (s_r.tap == cts_pkg::CTS_CIR) begin
				s_nxt.ir_sh = cts_pkg::CTS_IR_CAPTURE;
			end else if (s_r.tap == cts_pkg::CTS_SIR) begin
				s_nxt.ir_sh = {tdi_s, s_r.ir_sh[3:1]};
			end else if (s_r.tap == cts_pkg::CTS_UIR) begin
				s_nxt.ir = s_r.ir_sh;
			end
		end

		// Data out changes on the falling test clock edge
		if (tck_fall) begin
			s_nxt.tdo_en = (s_r.tap == cts_pkg::CTS_SDR) || (s_r.tap == cts_pkg::CTS_SIR);
			s_nxt.tdo = (s_r.tap == cts_pkg::CTS_SIR) ? s_r.ir_sh[0] : s_r.dr[0];
		end

		// ==========================================================
		// Debug entry and exit
		// Resume may be loaded by the very rise that enters run-test/idle, so look at the new value
		if (tck_rise && s_r.dbg_ack && s_nxt.ir == cts_pkg::CTS_IR_RESUME && tap_after == cts_pkg::CTS_RTI) begin
			s_nxt.dbg_ack = 1'b0;
		end else if (debug_entry_req && !s_r.dbg_ack && mclk_s) begin
			s_nxt.dbg_ack = 1'b1;
		end

		// A debug pulse starts only on a rise that stays in run-test/idle and lasts the whole
		// high phase, so entering or leaving that state yields no runt pulse; extest never pulses it
		if (debug_core_clock_chain && s_r.tap == cts_pkg::CTS_RTI && tck_rise && tap_after == cts_pkg::CTS_RTI) begin
			s_nxt.dbg_clk = 1'b1;
		end else if (debug_core_clock_chain && s_r.dbg_clk && tck_s) begin
			s_nxt.dbg_clk = 1'b1;
		end else begin
			s_nxt.dbg_clk = 1'b0;
		end

		// Memory waits mean nothing to a core stepped from the test port
		s_nxt.stall_n = sel_debug ? 1'b1 : stall_s;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_r <= CTS_MAIN_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	// Every output is a register, either here or inside the clock switch
	assign tdo = s_r.tdo;
	assign tdo_en = s_r.tdo_en;
	assign debug_acknowledge = s_r.dbg_ack;
	assign debug_core_clock = s_r.dbg_clk;
	assign core_on_debug_clock = sel_debug;
	assign core_stall_n = s_r.stall_n;
	assign active_chain = s_r.chain;
	assign tag_rd_req = s_r.tag_req;
	assign tag_rd_dcache = s_r.tag_dc;
	assign tag_rd_segment = s_r.tag_seg;
	assign tag_rd_index = s_r.tag_idx;
	assign cp_req = s_r.cp_req;
	assign cp_write = s_r.cp_wr;
	assign cp_addr = s_r.cp_addr;
	assign cp_wdata = s_r.cp_wdata;

endmodule

`default_nettype wire

// ---- cts_props.sv ----
// Port-level assertions for the debug scan block
`default_nettype none

module cts_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic debug_acknowledge,
	input wire logic debug_core_clock,
	input wire logic selected_clock_out,
	input wire logic core_on_debug_clock,
	input wire logic core_stall_n,
	input wire logic [4:0] active_chain,
	input wire logic tag_rd_req,
	input wire logic tag_rd_ack,
	input wire logic tag_rd_dcache,
	input wire logic cp_req,
	input wire logic cp_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Clock switching
	sequence s_on_dbg;
		!core_on_debug_clock ##[1:16] core_on_debug_clock;
	endsequence
	property p_enter_switch;
		$rose(debug_acknowledge) |-> s_on_dbg;
	endproperty
	a_enter_switch: assert property (p_enter_switch) else $error("debug clock not taken");
	property p_stall_ignored;
		core_on_debug_clock && $past(core_on_debug_clock) |-> core_stall_n;
	endproperty
	a_stall_ignored: assert property (p_stall_ignored) else $error("stall reached core");
	property p_dbg_low;
		!debug_acknowledge && active_chain != 5'h00 |-> !debug_core_clock;
	endproperty
	a_dbg_low: assert property (p_dbg_low) else $error("debug clock not held low");
	property p_sel_follow;
		core_on_debug_clock && $rose(debug_core_clock) |-> ##[0:1] selected_clock_out;
	endproperty
	a_sel_follow: assert property (p_sel_follow) else $error("selected clock lost pulse");
	property p_glitch;
		$changed(core_on_debug_clock) |-> !debug_core_clock && !selected_clock_out;
	endproperty
	a_glitch: assert property (p_glitch) else $error("switch while a clock is high");
	property p_test_clk;
		debug_core_clock |-> active_chain inside {5'h00, 5'h01};
	endproperty
	a_test_clk: assert property (p_test_clk) else $error("debug clock on wrong chain");

	// ==========================================================
	// Side accesses
	property p_tag_done;
		tag_rd_req && tag_rd_ack |=> !tag_rd_req;
	endproperty
	a_tag_done: assert property (p_tag_done) else $error("tag request held after answer");
	property p_tag_array;
		tag_rd_req && $past(tag_rd_req) |-> tag_rd_dcache == (active_chain == 5'h05);
	endproperty
	a_tag_array: assert property (p_tag_array) else $error("wrong tag array");
	property p_tag_src;
		$rose(tag_rd_req) |-> active_chain inside {5'h04, 5'h05};
	endproperty
	a_tag_src: assert property (p_tag_src) else $error("tag access from other chain");
	property p_cp_done;
		cp_req && cp_ack |=> !cp_req && $past(active_chain) == 5'h0F;
	endproperty
	a_cp_done: assert property (p_cp_done) else $error("coprocessor request misbehaves");
endmodule

bind cts_debug_scan cts_props u_props (.*);

`default_nettype wire

// ---- cts_dbg_model.sv ----
// Debugger model driving the test port pins
`default_nettype none

module cts_dbg_model (
	input wire logic ref_clk,
	input wire logic tdo,
	output logic tck,
	output logic tms,
	output logic tdi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// ==========================================================
	// Test clock: 64 ns period, parked low between calls
	task automatic clk(input logic m, input logic dv, output logic q);
		tms <= m;
		tdi <= dv;
		repeat (8) @(posedge ref_clk);
		q = tdo;
		tck <= 1'b1;
		repeat (8) @(posedge ref_clk);
		tck <= 1'b0;
	endtask

	task automatic reset_tap;
		logic q;
		repeat (5) clk(1'b1, ~tdi, q);
		clk(1'b0, ~tdi, q);
	endtask

	task automatic idle(input int n);
		logic q;
		repeat (n) clk(1'b0, ~tdi, q);
	endtask

	// Idle to idle; LSB first; data line toggles once released
	task automatic scan(input logic ir, input int n, input logic [38:0] din, output logic [38:0] dout);
		logic q;
		clk(1'b1, 1'b0, q);
		if (ir) clk(1'b1, 1'b0, q);
		clk(1'b0, 1'b0, q);
		clk(1'b0, 1'b0, q);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			clk(i == n - 1, din[i], q);
			dout[i] = q;
		end
		clk(1'b1, ~din[n-1], q);
		clk(1'b0, ~din[n-1], q);
	endtask
endmodule

`default_nettype wire

// ---- test_cts_debug_scan.sv ----
// Self-checking bench for the debug scan block
`default_nettype none

module test_cts_debug_scan;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [26:0] TT = 27'h5A3C0F1;
	localparam logic [31:0] RD = 32'hC3C31234;
	localparam logic [38:0] WR = {1'b1, 6'h05, 32'hA5A50F0F};
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic tck, tms, tdi, tdo, tdo_en;
	logic memory_clock = 1'b0;
	logic memory_stall_n = 1'b1;
	logic debug_entry_req = 1'b0;
	logic tag_rd_ack = 1'b0, tag_rd_valid = 1'b0, tag_rd_dirty = 1'b0, cp_ack = 1'b0;
	logic [26:0] tag_rd_tag = 27'h0;
	logic [31:0] cp_rdata = 32'h0;
	logic debug_acknowledge, debug_core_clock, selected_clock_out, core_on_debug_clock, core_stall_n;
	logic tag_rd_req, tag_rd_dcache, cp_req, cp_write;
	logic [4:0] active_chain;
	logic [1:0] tag_rd_segment;
	logic [5:0] tag_rd_index, cp_addr;
	logic [31:0] cp_wdata;
	logic mclk_run = 1'b1;
	logic [2:0] mdiv = 3'h0;
	logic [8:0] seen_tag;
	logic [38:0] seen_cp, d;
	int error_cnt = 0, compares = 0, pulses = 0, shifts = 0;

	initial forever #2 ref_clk = ~ref_clk;
	cts_debug_scan dut (.*);
	cts_dbg_model m (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
	always @(posedge debug_core_clock) pulses++;
	always @(posedge tdo_en) shifts++;

	// ==========================================================
	// Memory clock (40 ns) and tag/coprocessor responder; data is junk outside the answer
	always @(posedge ref_clk) begin
		mdiv <= (mdiv == 3'h4) ? 3'h0 : mdiv + 3'h1;
		if (mdiv == 3'h4) memory_clock <= mclk_run & ~memory_clock;
		tag_rd_ack <= tag_rd_req & ~tag_rd_ack;
		tag_rd_valid <= tag_rd_req & ~tag_rd_ack;
		tag_rd_dirty <= tag_rd_dcache;
		tag_rd_tag <= (tag_rd_req & ~tag_rd_ack) ? TT : ~TT;
		cp_ack <= cp_req & ~cp_ack;
		cp_rdata <= (cp_req & ~cp_ack) ? RD : ~RD;
		if (tag_rd_req) seen_tag <= {tag_rd_dcache, tag_rd_segment, tag_rd_index};
		if (cp_req) seen_cp <= {cp_write, cp_addr, cp_wdata};
	end

	// ==========================================================
	// Tasks
	task automatic cmp(input logic [38:0] got, input logic [38:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic ir(input logic [3:0] v);
		shifts = 0;
		m.scan(1'b1, 4, {35'h0, v}, d);
		cmp(d, 39'h1, "instruction capture");
		cmp(shifts, 1, "instruction shift window");
	endtask

	task automatic chain(input logic [4:0] c, input logic [3:0] ins);
		ir(cts_pkg::CTS_IR_SCAN_SEL);
		shifts = 0;
		m.scan(1'b0, cts_pkg::CTS_SEL_LEN, {34'h0, c}, d);
		cmp(d, 39'h10, "select capture");
		cmp(shifts, 1, "data shift window");
		cmp(active_chain, c, "active chain");
		ir(ins);
	endtask

	task automatic wait_dbg(input logic v);
		for (int i = 0; i < 60 && core_on_debug_clock !== v; i++) @(posedge ref_clk);
		cmp(core_on_debug_clock, v, "clock source");
	endtask

	task automatic end_sim;
		$display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		#200us;
		error_cnt++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		end_sim();
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		cmp(active_chain, 5'h03, "reset chain");
		cmp(core_on_debug_clock, 1'b0, "reset clock source");
		m.reset_tap();
		for (int k = 4; k < 6; k++) begin
			chain(5'(k), cts_pkg::CTS_IR_INTERNAL_TEST);
			// Ones in the ignored middle bits, zeros in the spare segment and index bits
			m.scan(1'b0, 29, {10'h0, 1'b0, 6'h2A, 16'hFFFF, 4'h0, 2'h2}, d);
			cmp(seen_tag, {k == 5, 2'h2, 6'h2A}, "tag address");
			m.scan(1'b0, 29, 39'h0, d);
			cmp(d, {10'h0, 1'b1, k == 5, TT}, "tag read");
			$display("tag chain %0d test done", k);
		end
		chain(5'h0F, cts_pkg::CTS_IR_INTERNAL_TEST);
		m.scan(1'b0, 39, WR, d);
		cmp(seen_cp, WR, "coprocessor write");
		m.scan(1'b0, 39, {1'b0, 6'h2C, 32'h0}, d);
		cmp(d, WR, "coprocessor capture");
		cmp(seen_cp[38:32], 7'h2C, "coprocessor read");
		m.scan(1'b0, 39, 39'h0, d);
		cmp(d, {7'h2C, RD}, "coprocessor data");
		$display("coprocessor test done");
		memory_stall_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		cmp(core_stall_n, 1'b0, "stall forwarded");
		debug_entry_req <= 1'b1;
		for (int i = 0; i < 40 && debug_acknowledge !== 1'b1; i++) @(posedge ref_clk);
		debug_entry_req <= 1'b0;
		wait_dbg(1'b1);
		repeat (2) @(posedge ref_clk);
		cmp(core_stall_n, 1'b1, "stall ignored");
		chain(5'h01, cts_pkg::CTS_IR_INTERNAL_TEST);
		pulses = 0;
		m.idle(4);
		cmp(pulses, 4, "debug steps");
		ir(cts_pkg::CTS_IR_RESUME);
		wait_dbg(1'b0);
		cmp(debug_acknowledge, 1'b0, "debug left");
		$display("debug clock test done");
		chain(5'h00, cts_pkg::CTS_IR_EXTEST);
		pulses = 0;
		m.idle(4);
		cmp(pulses, 0, "external test clocks");
		mclk_run <= 1'b0;
		repeat (12) @(posedge ref_clk);
		ir(cts_pkg::CTS_IR_INTERNAL_TEST);
		pulses = 0;
		m.idle(4);
		cmp(pulses, 4, "internal test clocks");
		cmp(core_on_debug_clock, 1'b1, "test on debug clock");
		ir(cts_pkg::CTS_IR_RESUME);
		mclk_run <= 1'b1;
		wait_dbg(1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		cmp(active_chain, 5'h03, "second reset");
		$display("test mode done");
		end_sim();
	end
endmodule

`default_nettype wire
